// ==== hdl/tapc_pkg.sv ====
// Purpose: Shared constants and types for the test access port controller
// Assumes: Instruction and chain widths are fixed
// Notes: Identification value is arbitrary
package tapc_pkg;
    localparam int IR_W = 4;
    localparam int USR_W = 16;
    localparam int ID_W = 32;
    localparam int ID_TOP = 31;
    localparam int USR_TOP = 15;
    localparam int IR_TOP = 3;
    localparam int SAT_ONES = 5;
    localparam logic [2:0] ONES_MAX = 3'h5;
    localparam logic [2:0] ONES_ZERO = 3'h0;
    localparam logic [2:0] ONES_ONE = 3'h1;
    localparam logic [IR_W-1:0] IR_CAPTURE = 4'h1;
    localparam logic [IR_W-1:0] INSTR_EXTEST = 4'h0;
    localparam logic [IR_W-1:0] INSTR_IDCODE = 4'h1;
    localparam logic [IR_W-1:0] INSTR_SAMPLE = 4'h2;
    localparam logic [IR_W-1:0] INSTR_BYPASS = 4'hf;
    localparam logic [IR_W-1:0] HIDDEN_DEBUG_INSTR_A = 4'h8;
    localparam logic [IR_W-1:0] HIDDEN_DEBUG_INSTR_D = 4'hb;
    // Arbitrary identification value
    localparam logic [ID_W-1:0] ID_VALUE = 32'h1234_5001;
    localparam logic [USR_W-1:0] USR_RESET = 16'h0000;
    localparam logic [ID_W-1:0] ID_ZERO = 32'h0000_0000;
    localparam logic [IR_W-1:0] IR_ZERO = 4'h0;
    localparam logic BYP_CAPTURE = 1'b0;

    typedef enum logic [3:0] {
        ST_RESET, ST_IDLE, ST_SEL_DR, ST_CAP_DR, ST_SH_DR, ST_EX1_DR,
        ST_PAU_DR, ST_EX2_DR, ST_UPD_DR, ST_SEL_IR, ST_CAP_IR, ST_SH_IR,
        ST_EX1_IR, ST_PAU_IR, ST_EX2_IR, ST_UPD_IR
    } tapc_state_t;

    typedef struct packed {
        logic tck;
        logic tms;
        logic tdi;
    } tapc_pins_t;

    typedef struct packed {
        logic data;
        logic oe_n;
    } tapc_tdo_t;
endpackage

// ==== hdl/tapc_top.sv ====
// Purpose: Four-wire test access port with sixteen-state controller
// Assumes: Test clock far slower than sys_clk_in; pins synchronised here
// Notes: Debug instructions share the user chain and flag debug access
`timescale 1ns/1ps
`default_nettype none
module tapc_top
(
    input wire logic sys_clk_in,
    input wire logic reset_in,
    input wire logic ce_in,
    input wire tapc_pkg::tapc_pins_t pins_in,
    input wire logic test_port_fuse_in,
    input wire logic test_port_disable_bit_in,
    input wire logic ocd_enable_in,
    input wire logic [tapc_pkg::USR_W-1:0] dr_capture_in,
    output tapc_pkg::tapc_tdo_t tdo_out,
    output logic pullup_en_out,
    output logic pins_as_gpio_out,
    output logic [tapc_pkg::IR_W-1:0] ir_out,
    output tapc_pkg::tapc_state_t state_out,
    output logic run_idle_out,
    output logic [tapc_pkg::USR_W-1:0] dr_update_out,
    output logic dr_update_strobe_out,
    output logic debug_access_out
);
    import tapc_pkg::*;

    function automatic tapc_state_t next_state(input tapc_state_t s, input logic tms);
        case (s)
            ST_RESET: next_state = tms ? ST_RESET : ST_IDLE;
            ST_IDLE: next_state = tms ? ST_SEL_DR : ST_IDLE;
            ST_SEL_DR: next_state = tms ? ST_SEL_IR : ST_CAP_DR;
            ST_CAP_DR: next_state = tms ? ST_EX1_DR : ST_SH_DR;
            ST_SH_DR: next_state = tms ? ST_EX1_DR : ST_SH_DR;
            ST_EX1_DR: next_state = tms ? ST_UPD_DR : ST_PAU_DR;
            ST_PAU_DR: next_state = tms ? ST_EX2_DR : ST_PAU_DR;
            ST_EX2_DR: next_state = tms ? ST_UPD_DR : ST_SH_DR;
            ST_UPD_DR: next_state = tms ? ST_SEL_DR : ST_IDLE;
            ST_SEL_IR: next_state = tms ? ST_RESET : ST_CAP_IR;
            ST_CAP_IR: next_state = tms ? ST_EX1_IR : ST_SH_IR;
            ST_SH_IR: next_state = tms ? ST_EX1_IR : ST_SH_IR;
            ST_EX1_IR: next_state = tms ? ST_UPD_IR : ST_PAU_IR;
            ST_PAU_IR: next_state = tms ? ST_EX2_IR : ST_PAU_IR;
            ST_EX2_IR: next_state = tms ? ST_UPD_IR : ST_SH_IR;
            ST_UPD_IR: next_state = tms ? ST_SEL_DR : ST_IDLE;
            default: next_state = ST_RESET;
        endcase
    endfunction

    // Pin synchronisers; stage one feeds only stage two
    tapc_pins_t sync1_reg;
    tapc_pins_t sync2_reg;
    logic tck_prev_reg;
    tapc_state_t state_reg;
    logic [IR_W-1:0] ir_sr_reg;
    logic [IR_W-1:0] ir_reg;
    logic byp_reg;
    logic [ID_W-1:0] id_sr_reg;
    logic [USR_W-1:0] usr_sr_reg;
    logic [USR_W-1:0] usr_out_reg;
    logic upd_strobe_reg;
    logic tdo_reg;
    logic oe_n_reg;
    logic [2:0] ones_reg;

    wire logic port_en = test_port_fuse_in & ~test_port_disable_bit_in;
    wire logic tck_rise = ce_in & sync2_reg.tck & ~tck_prev_reg;
    wire logic tck_fall = ce_in & ~sync2_reg.tck & tck_prev_reg;
    wire logic tms = sync2_reg.tms;
    wire logic tdi = sync2_reg.tdi;
    wire logic is_debug = (ir_reg >= HIDDEN_DEBUG_INSTR_A) && (ir_reg <= HIDDEN_DEBUG_INSTR_D);
    wire logic sel_id = (ir_reg == INSTR_IDCODE);
    wire logic sel_usr = (ir_reg == INSTR_EXTEST) || (ir_reg == INSTR_SAMPLE)
        || (is_debug && ocd_enable_in);
    wire logic sel_byp = ~sel_id & ~sel_usr;
    wire logic in_sh_dr = (state_reg == ST_SH_DR);
    wire logic in_sh_ir = (state_reg == ST_SH_IR);
    wire logic dr_bit = sel_id ? id_sr_reg[0] : (sel_usr ? usr_sr_reg[0] : byp_reg);
    wire logic out_bit = in_sh_ir ? ir_sr_reg[0] : dr_bit;
    wire tapc_state_t state_next = next_state(state_reg, tms);

    // Reset by reset_in, by port disable or by TMS; there is no test reset pin
    always_ff @(posedge sys_clk_in)
    begin
        if (reset_in || !port_en)
        begin
            state_reg <= ST_RESET;
            ir_reg <= INSTR_IDCODE;
            upd_strobe_reg <= 1'b0;
        end
        else if (ce_in)
        begin
            upd_strobe_reg <= tck_rise && state_reg == ST_UPD_DR && sel_usr;
            if (tck_rise)
            begin
                state_reg <= state_next;
                if (state_reg == ST_RESET)
                    ir_reg <= INSTR_IDCODE;
                else if (state_reg == ST_UPD_IR)
                    ir_reg <= ir_sr_reg;
            end
        end
    end

    always_ff @(posedge sys_clk_in)
    begin
        if (reset_in)
        begin
            sync1_reg <= '0;
            sync2_reg <= '0;
            tck_prev_reg <= 1'b0;
        end
        else if (ce_in)
        begin
            sync1_reg <= pins_in;
            sync2_reg <= sync1_reg;
            tck_prev_reg <= sync2_reg.tck;
        end
    end

    // Instruction path: capture fixed pattern, shift LSB first
    always_ff @(posedge sys_clk_in)
    begin
        if (reset_in)
            ir_sr_reg <= IR_ZERO;
        else if (tck_rise && state_reg == ST_CAP_IR)
            ir_sr_reg <= IR_CAPTURE;
        else if (tck_rise && in_sh_ir)
            ir_sr_reg <= {tdi, ir_sr_reg[IR_TOP:1]};
    end

    // Data paths: only the selected register moves
    always_ff @(posedge sys_clk_in)
    begin
        if (reset_in)
        begin
            byp_reg <= BYP_CAPTURE;
            id_sr_reg <= ID_ZERO;
            usr_sr_reg <= USR_RESET;
        end
        else if (tck_rise && state_reg == ST_CAP_DR)
        begin
            if (sel_byp)
                byp_reg <= BYP_CAPTURE;
            if (sel_id)
                id_sr_reg <= ID_VALUE;
            if (sel_usr)
                usr_sr_reg <= dr_capture_in;
        end
        else if (tck_rise && in_sh_dr)
        begin
            if (sel_byp)
                byp_reg <= tdi;
            if (sel_id)
                id_sr_reg <= {tdi, id_sr_reg[ID_TOP:1]};
            if (sel_usr)
                usr_sr_reg <= {tdi, usr_sr_reg[USR_TOP:1]};
        end
    end

    // Parallel output is held through shifting so the pins see no ripple
    always_ff @(posedge sys_clk_in)
    begin
        if (reset_in)
            usr_out_reg <= USR_RESET;
        else if (tck_rise && state_reg == ST_UPD_DR && sel_usr)
            usr_out_reg <= usr_sr_reg;
    end

    // TDO moves on falling TCK so the host samples a settled bit
    always_ff @(posedge sys_clk_in)
    begin
        if (reset_in || !port_en)
        begin
            tdo_reg <= 1'b0;
            oe_n_reg <= 1'b1;
        end
        else if (tck_fall)
        begin
            tdo_reg <= out_bit;
            oe_n_reg <= ~(in_sh_dr | in_sh_ir);
        end
    end

    // Consecutive TMS-high count, watched by a check only
    always_ff @(posedge sys_clk_in)
    begin
        if (reset_in || !port_en)
            ones_reg <= ONES_ZERO;
        else if (tck_rise)
            ones_reg <= !tms ? ONES_ZERO : (ones_reg == ONES_MAX ? ONES_MAX : ones_reg + ONES_ONE);
    end

    assign tdo_out.data = tdo_reg;
    assign tdo_out.oe_n = oe_n_reg;
    assign pullup_en_out = port_en;
    assign pins_as_gpio_out = ~port_en;
    assign ir_out = ir_reg;
    assign state_out = state_reg;
    assign run_idle_out = (state_reg == ST_IDLE);
    assign dr_update_out = usr_out_reg;
    assign dr_update_strobe_out = upd_strobe_reg;
    assign debug_access_out = is_debug & ocd_enable_in;

    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (reset_in);

    sequence upd_ir_step;
        tck_rise && state_reg == ST_UPD_IR;
    endsequence

    sequence upd_dr_step;
        tck_rise && state_reg == ST_UPD_DR && sel_usr;
    endsequence

    a_fuse_holds_reset: assert property (!port_en |=> state_reg == ST_RESET)
        else $error("Controller left reset while port disabled");
    a_ir_capture_val: assert property (tck_rise && state_reg == ST_CAP_IR && port_en
        |=> ir_sr_reg == IR_CAPTURE)
        else $error("Instruction capture value wrong");
    a_ir_shift_lsb: assert property (tck_rise && in_sh_ir
        |=> ir_sr_reg == {$past(tdi), $past(ir_sr_reg[IR_TOP:1])})
        else $error("Instruction shift wrong");
    a_ir_update_latch: assert property (upd_ir_step ##1 port_en
        |-> ir_reg == $past(ir_sr_reg))
        else $error("Instruction not latched in Update-IR");
    a_dr_update_only: assert property (usr_out_reg != $past(usr_out_reg)
        |-> $past(tck_rise && state_reg == ST_UPD_DR && sel_usr))
        else $error("Data output changed outside Update-DR");
    a_dr_strobe_pair: assert property (upd_dr_step ##1 port_en |-> dr_update_strobe_out)
        else $error("Update strobe missing");
    a_tdo_float: assert property (tck_fall && !in_sh_dr && !in_sh_ir
        |=> tdo_out.oe_n)
        else $error("TDO driven outside shift");
    a_bypass_zero: assert property (tck_rise && state_reg == ST_CAP_DR && sel_byp && port_en
        |=> !byp_reg)
        else $error("Bypass capture not zero");
    a_nav_no_action: assert property (tck_rise && (state_reg == ST_EX1_DR
        || state_reg == ST_PAU_DR || state_reg == ST_EX2_DR || state_reg == ST_EX1_IR
        || state_reg == ST_PAU_IR || state_reg == ST_EX2_IR)
        |=> $stable(ir_sr_reg) && $stable(usr_sr_reg) && $stable(ir_reg))
        else $error("Navigation state changed a register");
    a_five_ones_reset: assert property (ones_reg == ONES_MAX |-> state_reg == ST_RESET)
        else $error("Five TMS-high clocks did not reset");
    a_private_gated: assert property (is_debug && !ocd_enable_in |-> sel_byp)
        else $error("Debug chain selected without debug enable");
endmodule
`default_nettype wire

// ==== test/tap_test_access_controller_bench.sv ====
// Purpose: Self-checking bench for the test port controller
// Assumes: Host model drives the pins asynchronously
// Notes: Clock enable is tied high
`timescale 1ns/1ps
`default_nettype none
module tap_test_access_controller_bench;
    import tapc_pkg::*;
    logic sys_clk_in = 1'b0;
    logic reset_in = 1'b1;
    logic fuse = 1'b1;
    logic dis = 1'b0;
    logic ocd = 1'b0;
    logic [USR_W-1:0] cap = 16'h3c5a;
    tapc_pins_t pins;
    tapc_tdo_t tdo;
    logic pull, gpio, idle, stb, dbg;
    logic [IR_W-1:0] ir;
    tapc_state_t st;
    logic [USR_W-1:0] upd;
    logic [31:0] q;
    int n_fail = 0;
    int checked = 0;
    int cyc = 0;
    int n_stb = 0;
    tapc_top tapc_top_i (.sys_clk_in(sys_clk_in), .reset_in(reset_in), .ce_in(1'b1),
        .pins_in(pins), .test_port_fuse_in(fuse), .test_port_disable_bit_in(dis),
        .ocd_enable_in(ocd), .dr_capture_in(cap), .tdo_out(tdo), .pullup_en_out(pull),
        .pins_as_gpio_out(gpio), .ir_out(ir), .state_out(st), .run_idle_out(idle),
        .dr_update_out(upd), .dr_update_strobe_out(stb), .debug_access_out(dbg));
    tapc_host_model tapc_host_model_i (.pins_out(pins), .tdo_in(tdo));
    initial
    begin
        forever #2.5 sys_clk_in = ~sys_clk_in;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic results();
        $display("checked %0d failed %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // Ceiling well above the roughly 3300 cycles the tests need
    always @(posedge sys_clk_in)
    begin
        cyc++;
        if (stb === 1'b1)
            n_stb++;
        if (cyc == 40000)
        begin
            n_fail++;
            results();
        end
    end
    task automatic t_reset();
        check(st, ST_RESET);
        check(ir, INSTR_IDCODE);
        check({tdo.oe_n, upd}, 17'h1_0000);
        check({pull, gpio, idle}, 3'h4);
        tapc_host_model_i.walk(8'h00, 1);
        check(idle, 1'b1);
    endtask
    task automatic t_ir();
        logic [3:0] codes [4] = '{INSTR_EXTEST, INSTR_SAMPLE, INSTR_BYPASS, INSTR_IDCODE};
        foreach (codes[i])
        begin
            tapc_host_model_i.ir_scan(codes[i], q);
            check(q, IR_CAPTURE);
            check(ir, codes[i]);
            check({idle, tdo.oe_n}, 2'h3);
        end
    endtask
    task automatic t_id();
        tapc_host_model_i.dr_scan(ID_W, 32'h0000_0000, q);
        check(q, ID_VALUE);
    endtask
    task automatic t_user();
        int n0;
        n0 = n_stb;
        tapc_host_model_i.ir_scan(INSTR_EXTEST, q);
        tapc_host_model_i.walk(8'h01, 3);
        tapc_host_model_i.shift(USR_W, 32'h0000_a55a, q);
        tapc_host_model_i.walk(8'h00, 1);
        check({st, upd}, {ST_PAU_DR, USR_RESET});
        tapc_host_model_i.walk(8'h03, 3);
        check(q, cap);
        check(upd, 16'ha55a);
        check(n_stb, n0 + 1);
    endtask
    task automatic t_bypass();
        tapc_host_model_i.ir_scan(INSTR_BYPASS, q);
        tapc_host_model_i.dr_scan(8, 32'h0000_00a5, q);
        check(q, 32'h0000_004a);
    endtask
    task automatic t_debug();
        for (int c = 8; c < 12; c++)
        begin
            @(negedge sys_clk_in);
            ocd = 1'b0;
            tapc_host_model_i.ir_scan(c[3:0], q);
            check(dbg, 1'b0);
            tapc_host_model_i.dr_scan(8, 32'h0000_00a5, q);
            check(q, 32'h0000_004a);
            @(negedge sys_clk_in);
            ocd = 1'b1;
            @(negedge sys_clk_in);
            check(dbg, 1'b1);
        end
    endtask
    task automatic t_five();
        tapc_host_model_i.ir_scan(INSTR_SAMPLE, q);
        tapc_host_model_i.walk(8'h01, 3);
        tapc_host_model_i.walk(8'h1f, 5);
        check(st, ST_RESET);
        // Instruction falls back on the first rise spent in Test-Logic-Reset
        tapc_host_model_i.walk(8'h01, 1);
        check({st, ir}, {ST_RESET, INSTR_IDCODE});
    endtask
    task automatic t_disable();
        @(negedge sys_clk_in);
        fuse = 1'b0;
        tapc_host_model_i.walk(8'h00, 3);
        check({gpio, pull, st}, {2'h2, ST_RESET});
        @(negedge sys_clk_in);
        fuse = 1'b1;
        dis = 1'b1;
        tapc_host_model_i.walk(8'h00, 3);
        check({pull, st, tdo.oe_n}, {1'b0, ST_RESET, 1'b1});
        @(negedge sys_clk_in);
        dis = 1'b0;
        tapc_host_model_i.walk(8'h00, 1);
        check({pull, gpio, idle}, 3'h5);
    endtask
    initial
    begin
        repeat (20) @(negedge sys_clk_in);
        reset_in = 1'b0;
        repeat (4) @(negedge sys_clk_in);
        t_reset();
        t_ir();
        t_id();
        t_user();
        t_bypass();
        t_debug();
        t_five();
        t_disable();
        results();
    end
endmodule
`default_nettype wire

// ==== test/tapc_host_model.sv ====
// Purpose: Host side driving the test port pins
// Assumes: Line has a pull-up while the port floats
// Notes: Test clock stands low between calls
`timescale 1ns/1ps
`default_nettype none
module tapc_host_model
(
    output tapc_pkg::tapc_pins_t pins_out,
    input wire tapc_pkg::tapc_tdo_t tdo_in
);
    import tapc_pkg::*;
    logic tdo_w;
    initial pins_out = 3'h3;
    assign tdo_w = tdo_in.oe_n ? 1'b1 : tdo_in.data;
    // Sample before the rise, after the data settled on the fall
    task automatic step(input logic tms, input logic tdi, output logic tdo);
        pins_out.tms = tms;
        pins_out.tdi = tdi;
        #32;
        tdo = tdo_w;
        pins_out.tck = 1'b1;
        #32;
        pins_out.tck = 1'b0;
    endtask
    task automatic walk(input logic [7:0] seq, input int n);
        logic b;
        for (int i = 0; i < n; i++)
            step(seq[i], 1'b0, b);
    endtask
    task automatic shift(input int n, input logic [31:0] d, output logic [31:0] q);
        logic b;
        q = '0;
        for (int i = 0; i < n; i++)
        begin
            step(i == n - 1, d[i], b);
            q[i] = b;
        end
    endtask
    task automatic ir_scan(input logic [3:0] c, output logic [31:0] q);
        walk(8'h03, 4);
        shift(4, {28'h000_0000, c}, q);
        walk(8'h01, 2);
    endtask
    task automatic dr_scan(input int n, input logic [31:0] d, output logic [31:0] q);
        walk(8'h01, 3);
        shift(n, d, q);
        walk(8'h01, 2);
    endtask
endmodule
`default_nettype wire
